/* File: design/clock_buffer_config_and_input_mux.sv */
// Purpose: strap decoding, continuous pin sampling, divider and mode control
// Assumes: each strap reaches us as a 2-bit sensed code, asynchronous to clk_in
// Notes: serial protocol engines and register map sit outside this block

// How it works
// - in pin mode, straps sensed as high, low or open set the whole configuration
// - input select and output enable pins are sampled every cycle
// - output type strap: low LVDS, high HCSL, open LVCMOS, all outputs
// - pin mode edge strap: low slow, high medium, open fast, all outputs
// - output enable low tri-states every output, high enables them
// - input type strap: low LVDS, high HCSL, open LVCMOS, both inputs
// - pin mode divider strap: low /2, high /4, open /1
// - divide by eight only through host settings
// - select low uses input one, high input two, open automatic
// - automatic mode prefers input one whenever it is present
// - on loss of input one switch at first rising edge of input two
// - mux output held low during failover
// - four whole cycles of returned input one before switching back
// - on switch back output stays high until next falling edge
// - mode strap read after reset: open pins, low SPI, high I2C
// - reset from power-on reset or software reset bit, host mode only
// - host mode ignores enable pin; per-output enable, type, edge
// - host mode reuses strap pins as serial pins
// - host mode select from pin or from register setting
// - host mode power-down from register only
module clock_buffer_config_and_input_mux #(
    parameter int NUM_OUT = clkbuf_pkg::NUM_OUTPUTS
) (
    // clock and power-on reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // sensed pins, each a three-level code
    input wire logic [1:0] mode_strap_in,
    input wire logic [1:0] output_type_strap_in,
    input wire logic [1:0] edge_rate_strap_in,
    input wire logic [1:0] input_type_strap_in,
    input wire logic [1:0] second_input_divider_in,
    input wire logic [1:0] input_select_pin_in,
    input wire logic [1:0] out_enable_pin_in,
    // raw clock inputs
    input wire logic clock_input_one_in,
    input wire logic clock_input_two_in,
    // host register settings
    input wire logic [NUM_OUT-1:0] host_out_enable_in,
    input wire logic [2*NUM_OUT-1:0] host_out_type_in,
    input wire logic [2*NUM_OUT-1:0] host_edge_rate_in,
    input wire logic [1:0] host_input_type_in,
    input wire logic [1:0] host_divider_in,
    input wire logic host_sel_by_reg_in,
    input wire logic [1:0] host_sel_in,
    input wire logic host_soft_reset_in,
    input wire logic host_power_down_in,
    input wire logic spi_data_out_in,
    input wire logic spi_data_out_en_in,
    // configuration results
    output logic [1:0] config_mode_out,
    output logic config_ready_out,
    output logic [NUM_OUT-1:0] out_enable_out,
    output logic [2*NUM_OUT-1:0] out_type_out,
    output logic [2*NUM_OUT-1:0] edge_rate_out,
    output logic [1:0] input_type_out,
    output logic [1:0] input_divider_setting_out,
    output logic input_one_on_out,
    output logic input_two_on_out,
    // multiplexer results
    output logic mux_clk_out,
    output logic mux_src_two_out,
    output logic input_one_lost_out,
    // reused pins in host mode
    output logic serial_clk_out,
    output logic serial_data_in_out,
    output logic serial_select_out,
    output logic spi_pin_data_out,
    output logic spi_pin_oe_out
);
    import clkbuf_pkg::*;

    if (NUM_OUT < 1 || NUM_OUT > 64) begin : g_bad_num_out
        $error("NUM_OUT out of range");
    end

    typedef enum logic [2:0] {
        C_RESET = 3'h1,
        C_SETTLE = 3'h2,
        C_RUN = 3'h4
    } cfg_state_e;

    localparam logic [1:0] SETTLE_MAX = 2'(SETTLE_CYCLES);

    typedef struct packed {
        cfg_state_e state;
        logic [1:0] settle_cnt;
        logic [PIN_BITS-1:0] meta;
        logic [PIN_BITS-1:0] sync;
        logic [1:0] mode;
        logic [1:0] otype;
        logic [1:0] edge_rate;
        logic [1:0] itype;
        logic [1:0] itype_o;
        logic [1:0] div;
        logic prev_two;
        logic [2:0] div_cnt;
        logic two_div;
        logic soft_rst;
        logic [NUM_OUT-1:0] oe;
        logic [2*NUM_OUT-1:0] otype_o;
        logic [2*NUM_OUT-1:0] edge_o;
        logic [1:0] sel;
        logic in_one_on;
        logic in_two_on;
        logic ser_clk;
        logic ser_din;
        logic ser_sel;
        logic sdo;
        logic sdo_oe;
        logic power_down;
    } cfg_s;

    cfg_s cur_ff;
    cfg_s nxt_ff;
    cfg_s reset_val;
    logic [PIN_BITS-1:0] pins;
    logic host_mode;
    logic mux_nrst;

    mux_if link ();

    assign pins = {clock_input_two_in, clock_input_one_in, mode_strap_in,
                   output_type_strap_in, edge_rate_strap_in, input_type_strap_in,
                   second_input_divider_in, input_select_pin_in, out_enable_pin_in};
    assign host_mode = (cur_ff.mode != MODE_PIN);
    assign mux_nrst = nrst_in & ~cur_ff.soft_rst;

    always_comb begin
        reset_val = '0;
        reset_val.state = C_RESET;
        reset_val.mode = MODE_PIN;
        reset_val.otype = TRI_OPEN;
        reset_val.edge_rate = TRI_OPEN;
        reset_val.itype = TRI_OPEN;
        reset_val.div = DIV_BY1;
        reset_val.sel = TRI_OPEN;
    end

    // strap code to setting: low, high, open pick from three values
    function automatic logic [1:0] tri_map(input logic [1:0] code, input logic [1:0] lo,
                                           input logic [1:0] hi, input logic [1:0] op);
        logic [1:0] r;
        r = op;
        if (code == TRI_LOW) begin
            r = lo;
        end else if (code == TRI_HIGH) begin
            r = hi;
        end
        return r;
    endfunction

    always_comb begin
        logic [1:0] sel_code;
        logic [1:0] oe_code;
        logic pin_oe;
        logic rise2;
        logic [1:0] div_eff;
        sel_code = '0;
        oe_code = '0;
        pin_oe = 1'b0;
        rise2 = 1'b0;
        div_eff = '0;
        nxt_ff = cur_ff;
        // two flops on every pin before any logic looks at it
        nxt_ff.meta = pins;
        nxt_ff.sync = cur_ff.meta;
        nxt_ff.soft_rst = host_mode & host_soft_reset_in;
        unique case (cur_ff.state)
            C_RESET: begin
                nxt_ff.settle_cnt = '0;
                nxt_ff.state = C_SETTLE;
            end
            C_SETTLE: begin
                // wait until the synchroniser holds real pin values
                nxt_ff.settle_cnt = cur_ff.settle_cnt + 1'b1;
                if (cur_ff.settle_cnt == SETTLE_MAX) begin
                    nxt_ff.state = C_RUN;
                    nxt_ff.mode = tri_map(cur_ff.sync[PIN_MODE +: 2],
                                          MODE_SPI, MODE_I2C, MODE_PIN);
                    nxt_ff.otype = cur_ff.sync[PIN_OTYPE +: 2];
                    nxt_ff.edge_rate = cur_ff.sync[PIN_EDGE +: 2];
                    nxt_ff.itype = cur_ff.sync[PIN_ITYPE +: 2];
                    nxt_ff.div = tri_map(cur_ff.sync[PIN_DIV +: 2],
                                         DIV_BY2, DIV_BY4, DIV_BY1);
                end
            end
            C_RUN: begin
                nxt_ff.state = C_RUN;
            end
            default: begin
                nxt_ff.state = C_RESET;
            end
        endcase

        // the strap never yields /8, host setting may
        div_eff = host_mode ? host_divider_in : cur_ff.div;
        rise2 = cur_ff.sync[PIN_CLK2] & ~cur_ff.prev_two;
        nxt_ff.prev_two = cur_ff.sync[PIN_CLK2];
        if (rise2) begin
            nxt_ff.div_cnt = cur_ff.div_cnt + 1'b1;
        end
        unique case (div_eff)
            DIV_BY2: nxt_ff.two_div = nxt_ff.div_cnt[0];
            DIV_BY4: nxt_ff.two_div = nxt_ff.div_cnt[1];
            DIV_BY8: nxt_ff.two_div = nxt_ff.div_cnt[2];
            default: nxt_ff.two_div = cur_ff.sync[PIN_CLK2];
        endcase

        sel_code = (host_mode && host_sel_by_reg_in) ? host_sel_in
                                                     : cur_ff.sync[PIN_SEL +: 2];
        oe_code = cur_ff.sync[PIN_OE +: 2];
        // an open enable pin is reserved; treat it as disabled
        pin_oe = (oe_code == TRI_HIGH);
        nxt_ff.power_down = host_mode & host_power_down_in;
        nxt_ff.sel = sel_code;
        nxt_ff.in_one_on = (sel_code != TRI_HIGH) & ~nxt_ff.power_down;
        nxt_ff.in_two_on = (sel_code != TRI_LOW) & ~nxt_ff.power_down;
        nxt_ff.itype_o = host_mode ? host_input_type_in
            : tri_map(cur_ff.itype, ITYPE_LVDS, ITYPE_HCSL, ITYPE_LVCMOS);

        for (int i = 0; i < NUM_OUT; i++) begin
            if (host_mode) begin
                nxt_ff.oe[i] = host_out_enable_in[i] & ~nxt_ff.power_down;
                nxt_ff.otype_o[2*i +: 2] = host_out_type_in[2*i +: 2];
                nxt_ff.edge_o[2*i +: 2] = host_edge_rate_in[2*i +: 2];
            end else begin
                nxt_ff.oe[i] = pin_oe;
                nxt_ff.otype_o[2*i +: 2] = tri_map(cur_ff.otype, OTYPE_LVDS,
                                                   OTYPE_HCSL, OTYPE_LVCMOS);
                nxt_ff.edge_o[2*i +: 2] = tri_map(cur_ff.edge_rate, EDGE_SLOW,
                                                  EDGE_MEDIUM, EDGE_FAST);
            end
        end
        if (cur_ff.state != C_RUN) begin
            nxt_ff.oe = '0;
        end

        // strap pins become the serial port in host mode
        nxt_ff.ser_clk = host_mode & cur_ff.sync[PIN_OE];
        nxt_ff.ser_din = host_mode & cur_ff.sync[PIN_DIV];
        nxt_ff.ser_sel = host_mode & cur_ff.sync[PIN_EDGE];
        nxt_ff.sdo = spi_data_out_in;
        nxt_ff.sdo_oe = (cur_ff.mode == MODE_SPI) & spi_data_out_en_in;
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in || cur_ff.soft_rst) begin
            cur_ff <= reset_val;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign link.one_lvl = cur_ff.sync[PIN_CLK1];
    assign link.two_lvl = cur_ff.two_div;
    assign link.sel = cur_ff.sel;
    // outputs stay quiet until the straps are latched
    assign link.force_low = cur_ff.power_down | (cur_ff.state != C_RUN);

    smart_input_mux u_mux (
        .clk_in(clk_in),
        .nrst_in(mux_nrst),
        .link(link.mux)
    );

    assign config_mode_out = cur_ff.mode;
    assign config_ready_out = (cur_ff.state == C_RUN);
    assign out_enable_out = cur_ff.oe;
    assign out_type_out = cur_ff.otype_o;
    assign edge_rate_out = cur_ff.edge_o;
    assign input_type_out = cur_ff.itype_o;
    assign input_divider_setting_out = cur_ff.div;
    assign input_one_on_out = cur_ff.in_one_on;
    assign input_two_on_out = cur_ff.in_two_on;
    assign mux_clk_out = link.mux_clk;
    assign mux_src_two_out = link.src_two;
    assign input_one_lost_out = link.one_lost;
    assign serial_clk_out = cur_ff.ser_clk;
    assign serial_data_in_out = cur_ff.ser_din;
    assign serial_select_out = cur_ff.ser_sel;
    assign spi_pin_data_out = cur_ff.sdo;
    assign spi_pin_oe_out = cur_ff.sdo_oe;
endmodule

/* File: design/smart_input_mux.sv */
// Purpose: two-input clock selection, glitch-free in automatic mode, with priority failover
// Assumes: inputs oversampled by clk_in, at least two samples per phase
// Notes: loss of signal means no edge for LOS_CYCLES clocks
module smart_input_mux
    import clkbuf_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // link to configuration logic
    mux_if.mux link
);
    typedef enum logic [4:0] {
        S_ONE = 5'h01,
        S_FAIL = 5'h02,
        S_TWO = 5'h04,
        S_BACK = 5'h08,
        S_MAN = 5'h10
    } mux_state_e;

    localparam int LOS_W = $clog2(LOS_CYCLES + 1);
    localparam logic [LOS_W-1:0] LOS_MAX = LOS_W'(LOS_CYCLES);
    localparam logic [2:0] RISE_TARGET = 3'(RECOVER_CYCLES + 1);

    typedef struct packed {
        mux_state_e state;
        logic prev_one;
        logic prev_two;
        logic [LOS_W-1:0] los_cnt;
        logic [2:0] rise_cnt;
        logic out;
        logic src_two;
        logic lost;
    } mux_s;

    mux_s cur_ff;
    mux_s nxt_ff;

    always_comb begin
        logic rise1;
        logic fall1;
        logic rise2;
        rise1 = 1'b0;
        fall1 = 1'b0;
        rise2 = 1'b0;
        nxt_ff = cur_ff;
        rise1 = link.one_lvl & ~cur_ff.prev_one;
        fall1 = ~link.one_lvl & cur_ff.prev_one;
        rise2 = link.two_lvl & ~cur_ff.prev_two;
        nxt_ff.prev_one = link.one_lvl;
        nxt_ff.prev_two = link.two_lvl;
        if (rise1 | fall1) begin
            nxt_ff.los_cnt = '0;
        end else if (cur_ff.los_cnt != LOS_MAX) begin
            nxt_ff.los_cnt = cur_ff.los_cnt + 1'b1;
        end
        nxt_ff.lost = (nxt_ff.los_cnt == LOS_MAX);
        if (link.sel != TRI_OPEN) begin
            // manual choice follows the pin at once
            nxt_ff.state = S_MAN;
            nxt_ff.src_two = (link.sel == TRI_HIGH);
            nxt_ff.out = nxt_ff.src_two ? link.two_lvl : link.one_lvl;
        end else begin
            unique case (cur_ff.state)
                S_ONE, S_MAN: begin
                    nxt_ff.src_two = 1'b0;
                    if (cur_ff.lost) begin
                        nxt_ff.state = S_FAIL;
                        nxt_ff.out = 1'b0;
                    end else begin
                        nxt_ff.state = S_ONE;
                        nxt_ff.out = link.one_lvl;
                    end
                end
                S_FAIL: begin
                    nxt_ff.out = 1'b0;
                    if (rise2) begin
                        nxt_ff.state = S_TWO;
                        nxt_ff.src_two = 1'b1;
                        nxt_ff.out = 1'b1;
                        nxt_ff.rise_cnt = '0;
                    end
                end
                S_TWO: begin
                    nxt_ff.out = link.two_lvl;
                    if (nxt_ff.lost) begin
                        nxt_ff.rise_cnt = '0;
                    end else if (rise1) begin
                        nxt_ff.rise_cnt = cur_ff.rise_cnt + 1'b1;
                    end
                    // first rise opens a cycle, four more close four whole ones
                    if (nxt_ff.rise_cnt == RISE_TARGET) begin
                        nxt_ff.state = S_BACK;
                        nxt_ff.out = 1'b1;
                    end
                end
                S_BACK: begin
                    nxt_ff.out = 1'b1;
                    if (cur_ff.lost) begin
                        nxt_ff.state = S_FAIL;
                        nxt_ff.out = 1'b0;
                    end else if (fall1) begin
                        nxt_ff.state = S_ONE;
                        nxt_ff.src_two = 1'b0;
                        nxt_ff.out = 1'b0;
                    end
                end
                default: begin
                    nxt_ff.state = S_ONE;
                end
            endcase
        end
        if (link.force_low) begin
            nxt_ff.out = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            cur_ff <= '{state: S_ONE, los_cnt: '0, rise_cnt: '0, default: 1'b0};
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign link.mux_clk = cur_ff.out;
    assign link.src_two = cur_ff.src_two;
    assign link.one_lost = cur_ff.lost;
endmodule

/* File: inc/clkbuf_pkg.sv */
// Purpose: shared constants and types for the clock buffer configuration logic
// Assumes: straps arrive as 2-bit codes from three-level pin sensors
// Notes: one 10 ns system clock oversamples both clock inputs
package clkbuf_pkg;
    // three-level sensed pin codes
    localparam logic [1:0] TRI_LOW = 2'h0;
    localparam logic [1:0] TRI_HIGH = 2'h1;
    localparam logic [1:0] TRI_OPEN = 2'h2;
    // output type codes
    localparam logic [1:0] OTYPE_LVDS = 2'h0;
    localparam logic [1:0] OTYPE_HCSL = 2'h1;
    localparam logic [1:0] OTYPE_LVCMOS = 2'h2;
    // edge rate codes
    localparam logic [1:0] EDGE_SLOW = 2'h0;
    localparam logic [1:0] EDGE_MEDIUM = 2'h1;
    localparam logic [1:0] EDGE_FAST = 2'h2;
    // input level codes
    localparam logic [1:0] ITYPE_LVDS = 2'h0;
    localparam logic [1:0] ITYPE_HCSL = 2'h1;
    localparam logic [1:0] ITYPE_LVCMOS = 2'h2;
    // second input divide ratio codes
    localparam logic [1:0] DIV_BY1 = 2'h0;
    localparam logic [1:0] DIV_BY2 = 2'h1;
    localparam logic [1:0] DIV_BY4 = 2'h2;
    localparam logic [1:0] DIV_BY8 = 2'h3;
    // configuration mode codes
    localparam logic [1:0] MODE_PIN = 2'h0;
    localparam logic [1:0] MODE_SPI = 2'h1;
    localparam logic [1:0] MODE_I2C = 2'h2;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int LOS_TIME_NS = 200;
    localparam int LOS_CYCLES = (LOS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_CYCLES = 4;
    localparam int SETTLE_CYCLES = 2;
    localparam int NUM_OUTPUTS = 8;
    // packed pin bus positions
    localparam int PIN_OE = 0;
    localparam int PIN_SEL = 2;
    localparam int PIN_DIV = 4;
    localparam int PIN_ITYPE = 6;
    localparam int PIN_EDGE = 8;
    localparam int PIN_OTYPE = 10;
    localparam int PIN_MODE = 12;
    localparam int PIN_CLK1 = 14;
    localparam int PIN_CLK2 = 15;
    localparam int PIN_BITS = 16;
endpackage

/* File: inc/mux_if.sv */
// Purpose: link between configuration logic and the smart input multiplexer
// Assumes: all signals on clk_in
// Notes: clock levels are already synchronised, and input two is also divided
interface mux_if;
    logic one_lvl;
    logic two_lvl;
    logic [1:0] sel;
    logic force_low;
    logic mux_clk;
    logic src_two;
    logic one_lost;
    modport cfg (output one_lvl, output two_lvl, output sel, output force_low,
                 input mux_clk, input src_two, input one_lost);
    modport mux (input one_lvl, input two_lvl, input sel, input force_low,
                 output mux_clk, output src_two, output one_lost);
endinterface

/* File: tb/clock_buffer_config_and_input_mux_monitor.sv */
// Purpose: port-level checks of straps, pins and mux
// Assumes: pin sync adds three edges, so five steady samples suffice
// Notes: straps count only at reset release
module clock_buffer_config_and_input_mux_monitor
    import clkbuf_pkg::*;
#(
    parameter int NUM_OUT = 8
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [1:0] mode_strap_in,
    input wire logic [1:0] input_select_pin_in,
    input wire logic [1:0] out_enable_pin_in,
    input wire logic host_soft_reset_in,
    input wire logic [1:0] config_mode_out,
    input wire logic config_ready_out,
    input wire logic [NUM_OUT-1:0] out_enable_out,
    input wire logic [2*NUM_OUT-1:0] out_type_out,
    input wire logic [2*NUM_OUT-1:0] edge_rate_out,
    input wire logic [1:0] input_divider_setting_out,
    input wire logic input_one_on_out,
    input wire logic input_two_on_out,
    input wire logic mux_clk_out,
    input wire logic mux_src_two_out,
    input wire logic input_one_lost_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    wire pin_run = config_ready_out && config_mode_out == MODE_PIN;
    a_oe_high_on: assert property ((pin_run && out_enable_pin_in == TRI_HIGH)[*5]
        |-> out_enable_out == {NUM_OUT{1'b1}}) else $error("oe not set");
    a_oe_low_off: assert property ((pin_run && out_enable_pin_in == TRI_LOW)[*5]
        |-> out_enable_out == '0) else $error("oe not clear");
    a_sel_low_one: assert property ((pin_run && input_select_pin_in == TRI_LOW)[*5]
        |-> input_one_on_out && !input_two_on_out) else $error("one not on");
    a_sel_high_two: assert property ((pin_run && input_select_pin_in == TRI_HIGH)[*5]
        |-> !input_one_on_out && input_two_on_out) else $error("two not on");
    a_type_all_same: assert property (pin_run
        |-> out_type_out == {NUM_OUT{out_type_out[1:0]}}) else $error("types differ");
    a_edge_all_same: assert property (pin_run
        |-> edge_rate_out == {NUM_OUT{edge_rate_out[1:0]}}) else $error("edges differ");
    a_no_div_eight: assert property (pin_run
        |-> input_divider_setting_out != DIV_BY8) else $error("strap gave /8");
    a_failover_low: assert property ($past(input_one_lost_out) && input_one_lost_out
        && !mux_src_two_out |-> !mux_clk_out) else $error("high in failover");
    a_mode_spi_read: assert property ($rose(config_ready_out) && mode_strap_in == TRI_LOW
        |-> ##[0:1] config_mode_out == MODE_SPI) else $error("no spi mode");
    a_soft_reset: assert property (config_mode_out != MODE_PIN && host_soft_reset_in
        |-> ##[1:3] !config_ready_out) else $error("soft reset ignored");
endmodule
bind clock_buffer_config_and_input_mux clock_buffer_config_and_input_mux_monitor #(
    .NUM_OUT(NUM_OUT)
) u_monitor (
    .clk_in(clk_in), .nrst_in(nrst_in), .mode_strap_in(mode_strap_in),
    .input_select_pin_in(input_select_pin_in), .out_enable_pin_in(out_enable_pin_in),
    .host_soft_reset_in(host_soft_reset_in), .config_mode_out(config_mode_out),
    .config_ready_out(config_ready_out), .out_enable_out(out_enable_out),
    .out_type_out(out_type_out), .edge_rate_out(edge_rate_out),
    .input_divider_setting_out(input_divider_setting_out),
    .input_one_on_out(input_one_on_out), .input_two_on_out(input_two_on_out),
    .mux_clk_out(mux_clk_out), .mux_src_two_out(mux_src_two_out),
    .input_one_lost_out(input_one_lost_out)
);

/* File: tb/clock_buffer_config_and_input_mux_tb_top.sv */
// Purpose: scenarios for straps, pins, failover and host mode
// Assumes: inputs move on the falling edge
// Notes: the four data straps share one code per run
module clock_buffer_config_and_input_mux_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import clkbuf_pkg::*;
    logic clk_in, nrst_in, run_one, run_two, by_reg, soft_rst, pwr_dn;
    logic [1:0] mode_s, strap_s, sel_p, oe_p, h_sel, mode_o, itype_o, div_o;
    logic [7:0] h_oe, oe_o;
    logic [15:0] otype_o, edge_o;
    logic rdy_o, one_on, two_on, mclk, src_two, lost, s_clk, c_one, c_two;
    int n_mismatch, cmp_count, i;
    logic [1:0] ot_e [3] = '{OTYPE_LVDS, OTYPE_HCSL, OTYPE_LVCMOS};
    logic [1:0] er_e [3] = '{EDGE_SLOW, EDGE_MEDIUM, EDGE_FAST};
    logic [1:0] it_e [3] = '{ITYPE_LVDS, ITYPE_HCSL, ITYPE_LVCMOS};
    logic [1:0] dv_e [3] = '{DIV_BY2, DIV_BY4, DIV_BY1};
    clock_source_model u_clock_source_model (.run_one_in(run_one), .run_two_in(run_two),
        .clk_one_out(c_one), .clk_two_out(c_two));
    clock_buffer_config_and_input_mux u_clock_buffer_config_and_input_mux (
        .clk_in(clk_in), .nrst_in(nrst_in), .mode_strap_in(mode_s),
        .output_type_strap_in(strap_s), .edge_rate_strap_in(strap_s),
        .input_type_strap_in(strap_s), .second_input_divider_in(strap_s),
        .input_select_pin_in(sel_p), .out_enable_pin_in(oe_p),
        .clock_input_one_in(c_one), .clock_input_two_in(c_two),
        .host_out_enable_in(h_oe), .host_out_type_in({h_oe, h_oe}),
        .host_edge_rate_in({h_oe, ~h_oe}), .host_input_type_in(h_sel),
        .host_divider_in(2'h3), .host_sel_by_reg_in(by_reg), .host_sel_in(h_sel),
        .host_soft_reset_in(soft_rst), .host_power_down_in(pwr_dn),
        .spi_data_out_in(1'b0), .spi_data_out_en_in(1'b0),
        .config_mode_out(mode_o), .config_ready_out(rdy_o), .out_enable_out(oe_o),
        .out_type_out(otype_o), .edge_rate_out(edge_o), .input_type_out(itype_o),
        .input_divider_setting_out(div_o), .input_one_on_out(one_on),
        .input_two_on_out(two_on), .mux_clk_out(mclk), .mux_src_two_out(src_two),
        .input_one_lost_out(lost), .serial_clk_out(s_clk), .serial_data_in_out(),
        .serial_select_out(), .spi_pin_data_out(), .spi_pin_oe_out());
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic check_vec(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        check_vec(16'(got), 16'(exp));
    endtask
    task automatic bound_hit(input int n, input int lim);
        if (n >= lim) begin
            n_mismatch++;
            $display("MISMATCH at %0t: wait ran out", $time);
            finish_test();
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic do_reset(input logic [1:0] mode, input logic [1:0] code);
        @(negedge clk_in);
        nrst_in = 1'b0;
        mode_s = mode;
        strap_s = code;
        wait_n(2);
        nrst_in = 1'b1;
        for (i = 0; i < 20 && rdy_o !== 1'b1; i++) @(negedge clk_in);
        bound_hit(i, 20);
        wait_n(3);
    endtask
    // every strap level decodes to its own setting, latched at reset release
    task automatic t_straps();
        for (int c = 0; c < 3; c++) begin
            do_reset(TRI_OPEN, 2'(c));
            check_vec(mode_o, MODE_PIN);
            check_vec(otype_o, {8{ot_e[c]}});
            check_vec(edge_o, {8{er_e[c]}});
            check_vec(itype_o, it_e[c]);
            check_vec(div_o, dv_e[c]);
            strap_s = 2'(2 - c);
            wait_n(6);
            check_vec(otype_o, {8{ot_e[c]}});
        end
    endtask
    // enable pin toggled while running, answer three edges later
    task automatic t_oe();
        oe_p = TRI_LOW;
        wait_n(4);
        check_vec(oe_o, 8'h00);
        oe_p = TRI_HIGH;
        wait_n(4);
        check_vec(oe_o, 8'hFF);
    endtask
    task automatic t_sel();
        sel_p = TRI_LOW;
        wait_n(4);
        check_vec({one_on, two_on}, 2'h2);
        sel_p = TRI_HIGH;
        wait_n(8);
        check_vec({one_on, two_on, src_two}, 3'h3);
        sel_p = TRI_OPEN;
    endtask
    // input one dropped then restored, return must wait four of its cycles
    task automatic t_auto();
        do_reset(TRI_OPEN, TRI_OPEN);
        wait_n(30);
        check_bit(src_two, 1'b0);
        run_one = 1'b0;
        for (i = 0; i < 100 && src_two !== 1'b1; i++) @(negedge clk_in);
        bound_hit(i, 100);
        check_bit(lost, 1'b1);
        run_one = 1'b1;
        for (i = 0; i < 300 && src_two !== 1'b0; i++) @(negedge clk_in);
        bound_hit(i, 300);
        check_bit(i >= 32, 1'b1);
        check_vec({lost, mclk}, 2'h0);
    endtask
    task automatic t_host();
        do_reset(TRI_LOW, TRI_LOW);
        check_vec(mode_o, MODE_SPI);
        h_oe = 8'hA5;
        oe_p = TRI_LOW;
        wait_n(5);
        check_vec(oe_o, 8'hA5);
        check_bit(s_clk, 1'b0);
        oe_p = TRI_HIGH;
        by_reg = 1'b1;
        h_sel = TRI_HIGH;
        wait_n(8);
        check_vec(oe_o, 8'hA5);
        check_bit(s_clk, 1'b1);
        check_vec({one_on, two_on}, 2'h1);
        pwr_dn = 1'b1;
        wait_n(12);
        check_bit(mclk, 1'b0);
        pwr_dn = 1'b0;
        soft_rst = 1'b1;
        @(negedge clk_in);
        soft_rst = 1'b0;
        wait_n(2);
        check_bit(rdy_o, 1'b0);
    endtask
    initial begin
        n_mismatch = 0;
        cmp_count = 0;
        nrst_in = 1'b0;
        {run_one, run_two, by_reg, soft_rst, pwr_dn} = 5'h18;
        {mode_s, strap_s, sel_p, oe_p, h_sel} = {TRI_OPEN, TRI_OPEN, TRI_OPEN, TRI_HIGH, TRI_LOW};
        h_oe = 8'h00;
        wait_n(2);
        t_straps();
        t_oe();
        t_sel();
        t_auto();
        t_host();
        finish_test();
    end
endmodule

/* File: tb/clock_source_model.sv */
// Purpose: two free clock sources feeding the buffer inputs
// Assumes: periods 80 ns and 90 ns
// Notes: a stopped source rests low, which is how loss of signal looks
module clock_source_model #(
    parameter int HALF_ONE = 40,
    parameter int HALF_TWO = 45
) (
    // run controls
    input wire logic run_one_in,
    input wire logic run_two_in,
    // clock levels
    output logic clk_one_out,
    output logic clk_two_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        clk_one_out = 1'b0;
        clk_two_out = 1'b0;
    end
    // frequencies kept within a fifth of each other
    always begin
        #(HALF_ONE);
        clk_one_out = run_one_in ? ~clk_one_out : 1'b0;
    end
    always begin
        #(HALF_TWO);
        clk_two_out = run_two_in ? ~clk_two_out : 1'b0;
    end
endmodule
